// [src/flash_ctrl_pkg.sv]
// shared constants and types of the flash status and reset control block
package flash_ctrl_pkg;

    // clock rate and worst-case self-timed durations
    localparam int CLK_MHZ        = 50;
    localparam int T_XFR_MAX_US   = 150;
    localparam int T_EP_MAX_MS    = 20;
    localparam int T_P_MAX_MS     = 14;
    localparam int US_PER_MS      = 1000;
    localparam int XFR_CYCLES     = T_XFR_MAX_US * CLK_MHZ;
    localparam int EP_CYCLES      = T_EP_MAX_MS * US_PER_MS * CLK_MHZ;
    localparam int P_CYCLES       = T_P_MAX_MS * US_PER_MS * CLK_MHZ;
    localparam int TIMER_W        = 20;

    // serial framing
    localparam int         BIT_CNT_W      = 3;
    localparam logic [2:0] LAST_BIT_IDX   = 3'h7;
    localparam logic [2:0] MSB_IDX        = 3'h7;
    localparam logic [7:0] OP_STATUS_READ = 8'h57;

    // status byte layout
    localparam int         ST_READY_BIT   = 7;
    localparam int         ST_COMP_BIT    = 6;
    localparam logic [2:0] ST_RSVD_VAL    = 3'h0;
    localparam logic       COMP_RST_VAL   = 1'b0;

    // clock mode encoding: mode 0 idles low, mode 3 idles high
    localparam logic MODE_0        = 1'b0;
    localparam logic MODE_3        = 1'b1;
    localparam logic MODE_RST_VAL  = MODE_3;

    // idle levels the pin synchroniser starts from: resetN, csN, sck, si
    localparam logic [3:0] PIN_IDLE = 4'hC;

    typedef enum logic [1:0] {OP_XFR, OP_CMP, OP_ERASE_PROG, OP_PROG} op_kind_t;

    typedef enum logic [1:0] {LINK_OFF, LINK_OPCODE, LINK_STATUS, LINK_OTHER} link_state_t;

endpackage

// [src/pin_sync.sv]
// two-flop synchroniser for a group of pins
`timescale 1ns/1ns
module pin_sync #(
    parameter int               WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pinIn,
    output      logic [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_meta = pinIn;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign pinSync = sync_ff;
endmodule

// [src/op_timer.sv]
// down-counter that times one self-timed internal operation
`timescale 1ns/1ns
module op_timer (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               start,
    input  wire logic [flash_ctrl_pkg::TIMER_W-1:0] cycles,
    output      logic                               busy,
    output      logic                               done
);
    import flash_ctrl_pkg::*;

    logic [TIMER_W-1:0] count_ff;
    logic [TIMER_W-1:0] nxt_count;

    always_comb
    begin
        nxt_count = count_ff;
        if (start && count_ff == '0)
            nxt_count = cycles;
        else if (count_ff != '0)
            nxt_count = count_ff - TIMER_W'(1);
    end

    // reset aborts any operation in progress
    always_ff @(posedge clk)
    begin
        if (rst)
            count_ff <= '0;
        else
            count_ff <= nxt_count;
    end

    assign busy = count_ff != '0;
    assign done = count_ff == TIMER_W'(1);

    chk_timer_load: assert property (@(posedge clk) disable iff (rst)
        start && !busy |=> busy && count_ff == $past(cycles))
        else $error("timer did not load the operation length");
endmodule

// [src/serial_flash_status_reset_ctrl.sv]
// status byte, reset, busy pin and clock-mode control of a serial flash
`timescale 1ns/1ns
// How it works
// - reset pin low aborts the running operation and idles the state machine
// - device stays in reset while the reset pin is low, resumes when high
// - an internal power-on reset needs nothing from the reset pin
// - busy pin is pulled low during every self-timed operation, released otherwise
// - while busy only the other buffer stays reachable
// - after reset the clock mode is 3 and serial output floats
// - after reset nothing is accepted until chip select falls
// - each chip select fall picks mode 0 on clock low, mode 3 on high
// - serial input is taken on the rising serial clock edge in both modes
// - page-to-buffer transfer or compare is busy for at most 150 us
// - erase plus program takes at most 20 ms, program alone 14 ms
// - every opcode, address or data byte spans exactly eight clocks
// - opcode 57h streams the status byte MSB first, refreshed each byte
// - status bit 7 is one when ready, zero while busy
// - status bit 6 holds the result of the latest compare since reset, zero until one ends
// - status bits 5..3 hold a fixed density code, bits 2..0 reserved
module serial_flash_status_reset_ctrl #(
    parameter int         XFR_CYC      = flash_ctrl_pkg::XFR_CYCLES,
    parameter int         EP_CYC       = flash_ctrl_pkg::EP_CYCLES,
    parameter int         P_CYC        = flash_ctrl_pkg::P_CYCLES,
    // density code value is arbitrary
    parameter logic [2:0] DENSITY_CODE = 3'h5
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       resetN,
    input  wire logic                       csN,
    input  wire logic                       sck,
    input  wire logic                       si,
    output      logic                       soOut,
    output      logic                       soOe,
    output      logic                       rdyBusyOut,
    output      logic                       rdyBusyOe,
    input  wire logic                       opStart,
    input  wire flash_ctrl_pkg::op_kind_t   opKind,
    input  wire logic                       opBuffer,
    input  wire logic                       cmpMismatch,
    output      logic                       opAccepted,
    output      logic                       opDone,
    output      logic                       spiMode,
    output      logic [1:0]                 bufferLocked,
    output      logic                       statusCmd
);
    import flash_ctrl_pkg::*;

    logic                 resetNS;
    logic                 csNS;
    logic                 sckS;
    logic                 siS;
    logic                 devRst;
    logic                 busy;
    logic                 csFall;
    logic                 sckRise;
    logic                 sckFall;
    logic [7:0]           statusNow;
    logic [7:0]           rxByte;
    logic                 byteEnd;

    logic                 csPrev_ff;
    logic                 sckPrev_ff;
    link_state_t          link_ff;
    logic [BIT_CNT_W-1:0] bitCnt_ff;
    logic [7:0]           shift_ff;
    logic [BIT_CNT_W-1:0] outIdx_ff;
    logic [7:0]           snap_ff;
    logic                 soOut_ff;
    logic                 soOe_ff;
    logic                 showReady_ff;
    logic                 mode_ff;
    logic                 comp_ff;
    logic                 lockBuf_ff;
    op_kind_t             kindLat_ff;
    logic                 mismatchLat_ff;

    logic                 nxt_csPrev;
    logic                 nxt_sckPrev;
    link_state_t          nxt_link;
    logic [BIT_CNT_W-1:0] nxt_bitCnt;
    logic [7:0]           nxt_shift;
    logic [BIT_CNT_W-1:0] nxt_outIdx;
    logic [7:0]           nxt_snap;
    logic                 nxt_soOut;
    logic                 nxt_soOe;
    logic                 nxt_showReady;
    logic                 nxt_mode;
    logic                 nxt_comp;
    logic                 nxt_lockBuf;
    op_kind_t             nxt_kindLat;
    logic                 nxt_mismatchLat;

    function automatic logic [TIMER_W-1:0] opCycles(input op_kind_t kind);
        case (kind)
            OP_XFR, OP_CMP: opCycles = TIMER_W'(XFR_CYC);
            OP_ERASE_PROG:  opCycles = TIMER_W'(EP_CYC);
            OP_PROG:        opCycles = TIMER_W'(P_CYC);
            default:        opCycles = TIMER_W'(EP_CYC);
        endcase
    endfunction

    pin_sync #(
        .WIDTH (4),
        .INIT  (PIN_IDLE)
    ) u_pin_sync (
        .clk     (clk),
        .srst    (srst),
        .pinIn   ({resetN, csN, sck, si}),
        .pinSync ({resetNS, csNS, sckS, siS})
    );

    // power-on reset or reset pin low both hold the device idle
    assign devRst = srst | ~resetNS;

    op_timer u_op_timer (
        .clk    (clk),
        .rst    (devRst),
        .start  (opAccepted),
        .cycles (opCycles(opKind)),
        .busy   (busy),
        .done   (opDone)
    );

    // a new array operation waits until the running one ends
    assign opAccepted = opStart & ~busy & ~devRst;

    assign csFall  = csPrev_ff & ~csNS;
    assign sckRise = ~sckPrev_ff & sckS;
    assign sckFall = sckPrev_ff & ~sckS;
    assign rxByte  = {shift_ff[6:0], siS};
    assign byteEnd = sckRise && bitCnt_ff == LAST_BIT_IDX;

    assign statusNow = {~busy, comp_ff, DENSITY_CODE, ST_RSVD_VAL};

    always_comb
    begin
        nxt_csPrev      = csNS;
        nxt_sckPrev     = sckS;
        nxt_link        = link_ff;
        nxt_bitCnt      = bitCnt_ff;
        nxt_shift       = shift_ff;
        nxt_outIdx      = outIdx_ff;
        nxt_snap        = snap_ff;
        nxt_soOut       = soOut_ff;
        nxt_soOe        = soOe_ff;
        nxt_showReady   = showReady_ff;
        nxt_mode        = mode_ff;
        nxt_comp        = comp_ff;
        nxt_lockBuf     = lockBuf_ff;
        nxt_kindLat     = kindLat_ff;
        nxt_mismatchLat = mismatchLat_ff;

        if (csNS)
        begin
            nxt_link      = LINK_OFF;
            nxt_soOe      = 1'b0;
            nxt_showReady = 1'b0;
        end
        else if (csFall)
        begin
            // idle clock level at the fall picks the mode
            nxt_mode   = sckS ? MODE_3 : MODE_0;
            nxt_link   = LINK_OPCODE;
            nxt_bitCnt = '0;
        end
        else if (link_ff != LINK_OFF)
        begin
            if (sckRise)
            begin
                nxt_shift  = rxByte;
                nxt_bitCnt = bitCnt_ff + BIT_CNT_W'(1);
            end
            if (byteEnd && link_ff == LINK_OPCODE)
            begin
                nxt_link   = (rxByte == OP_STATUS_READ) ? LINK_STATUS : LINK_OTHER;
                nxt_outIdx = MSB_IDX;
            end
            if (link_ff == LINK_STATUS && sckFall)
            begin
                // fresh status at the start of every repeated byte
                if (outIdx_ff == MSB_IDX)
                begin
                    nxt_snap  = statusNow;
                    nxt_soOut = statusNow[ST_READY_BIT];
                end
                else
                begin
                    nxt_soOut = snap_ff[outIdx_ff];
                end
                nxt_soOe      = 1'b1;
                nxt_showReady = outIdx_ff == MSB_IDX;
                nxt_outIdx    = outIdx_ff - BIT_CNT_W'(1);
            end
            else if (showReady_ff)
            begin
                // clock parked on the ready bit: keep it live for polling
                nxt_soOut = statusNow[ST_READY_BIT];
            end
        end

        if (opAccepted)
        begin
            nxt_lockBuf     = opBuffer;
            nxt_kindLat     = opKind;
            nxt_mismatchLat = cmpMismatch;
        end
        if (opDone && kindLat_ff == OP_CMP)
            nxt_comp = mismatchLat_ff;
    end

    always_ff @(posedge clk)
    begin
        if (devRst)
        begin
            csPrev_ff      <= 1'b0;
            sckPrev_ff     <= 1'b0;
            link_ff        <= LINK_OFF;
            bitCnt_ff      <= '0;
            shift_ff       <= '0;
            outIdx_ff      <= '0;
            snap_ff        <= '0;
            soOut_ff       <= 1'b0;
            soOe_ff        <= 1'b0;
            showReady_ff   <= 1'b0;
            mode_ff        <= MODE_RST_VAL;
            comp_ff        <= COMP_RST_VAL;
            lockBuf_ff     <= 1'b0;
            kindLat_ff     <= OP_XFR;
            mismatchLat_ff <= 1'b0;
        end
        else
        begin
            csPrev_ff      <= nxt_csPrev;
            sckPrev_ff     <= nxt_sckPrev;
            link_ff        <= nxt_link;
            bitCnt_ff      <= nxt_bitCnt;
            shift_ff       <= nxt_shift;
            outIdx_ff      <= nxt_outIdx;
            snap_ff        <= nxt_snap;
            soOut_ff       <= nxt_soOut;
            soOe_ff        <= nxt_soOe;
            showReady_ff   <= nxt_showReady;
            mode_ff        <= nxt_mode;
            comp_ff        <= nxt_comp;
            lockBuf_ff     <= nxt_lockBuf;
            kindLat_ff     <= nxt_kindLat;
            mismatchLat_ff <= nxt_mismatchLat;
        end
    end

    // open drain: never drive high, pull low while busy
    assign rdyBusyOut   = 1'b0;
    assign rdyBusyOe    = busy;
    assign soOut        = soOut_ff;
    assign soOe         = soOe_ff;
    assign spiMode      = mode_ff;
    assign statusCmd    = link_ff == LINK_STATUS;
    assign bufferLocked = busy ? (lockBuf_ff ? 2'h2 : 2'h1) : 2'h0;

    // helper: cycles spent busy so far
    logic [TIMER_W-1:0] busyCnt_ff;
    logic [TIMER_W-1:0] nxt_busyCnt;
    always_comb
    begin
        nxt_busyCnt = busyCnt_ff + TIMER_W'(1);
        if (!busy)
            nxt_busyCnt = '0;
    end

    always_ff @(posedge clk)
    begin
        if (devRst)
            busyCnt_ff <= '0;
        else
            busyCnt_ff <= nxt_busyCnt;
    end

    chk_reset_idle: assert property (@(posedge clk)
        devRst |=> link_ff == LINK_OFF && !busy && !soOe)
        else $error("reset did not return the device to idle");

    chk_reset_hold: assert property (@(posedge clk)
        !resetNS [*2] |-> !busy && !opAccepted && link_ff == LINK_OFF)
        else $error("device left reset while the reset pin was low");

    chk_por_state: assert property (@(posedge clk)
        srst |=> spiMode == MODE_3 && !busy && comp_ff == COMP_RST_VAL)
        else $error("power-on reset state wrong");

    chk_busy_pin: assert property (@(posedge clk) disable iff (devRst)
        (rdyBusyOe == !statusNow[ST_READY_BIT] && rdyBusyOut == 1'b0)
        and (opAccepted |=> rdyBusyOe) and (opDone |=> !rdyBusyOe))
        else $error("busy pin and ready bit disagree");

    chk_buffer_lock: assert property (@(posedge clk) disable iff (devRst)
        opAccepted |=> (bufferLocked == (opBuffer ? 2'h2 : 2'h1)) [*2])
        else $error("wrong buffer locked during operation");

    chk_mode_reset: assert property (@(posedge clk)
        $fell(devRst) |-> spiMode == MODE_3 && !soOe)
        else $error("mode or output state wrong after reset");

    chk_need_cs_fall: assert property (@(posedge clk) disable iff (devRst)
        link_ff == LINK_OFF && !csFall |=> link_ff == LINK_OFF)
        else $error("link woke without a chip select fall");

    chk_mode_select: assert property (@(posedge clk) disable iff (devRst)
        csFall |=> spiMode == $past(sckS))
        else $error("clock mode not taken from idle clock level");

    chk_opcode_byte: assert property (@(posedge clk) disable iff (devRst)
        link_ff == LINK_OPCODE && byteEnd && rxByte == OP_STATUS_READ && !csNS
        |=> link_ff == LINK_STATUS)
        else $error("status opcode not recognised after eight clocks");

    chk_status_first: assert property (@(posedge clk) disable iff (devRst)
        link_ff == LINK_STATUS && sckFall && outIdx_ff == MSB_IDX && !csNS
        |=> soOe && soOut == $past(statusNow[ST_READY_BIT]))
        else $error("status byte not started with bit 7");

    chk_op_length: assert property (@(posedge clk) disable iff (devRst)
        opDone |-> busyCnt_ff == opCycles(kindLat_ff) - TIMER_W'(1))
        else $error("operation busy time wrong");

    chk_compare_bit: assert property (@(posedge clk) disable iff (devRst)
        opDone && kindLat_ff == OP_CMP |=> comp_ff == $past(mismatchLat_ff))
        else $error("compare result not stored");

    chk_density: assert property (@(posedge clk)
        statusNow[5:3] == DENSITY_CODE && statusNow[2:0] == ST_RSVD_VAL)
        else $error("density field wrong");
endmodule

// [tb/spi_host_model.sv]
// behavioural host controller that drives the serial link of the flash block
`timescale 1ns/1ns
module spi_host_model (
    output      logic csN,
    output      logic sck,
    output      logic si,
    input  wire logic soOut,
    input  wire logic soOe
);
    localparam int HALF_NS = 80;

    initial
    begin
        csN = 1'b1;
        sck = 1'b1;
        si  = 1'b0;
    end

    // chip select set by hand, used to leave it low across a reset
    task automatic hold_cs(input logic lvl);
        csN = lvl;
        #(4*HALF_NS);
    endtask

    // one frame: opcode out, then nrd bytes back; no fall if chip select is already low
    task automatic xfer(input logic mode, input logic [7:0] op, input int nrd,
                        output logic [15:0] rd, output logic oeSeen);
        rd     = '0;
        oeSeen = 1'b0;
        if (csN)
        begin
            sck = mode;                 // clock parked at its idle level picks the mode
            #(4*HALF_NS);
            csN = 1'b0;                 // a frame begun with chip select high opens with its fall
            #(4*HALF_NS);
        end
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            si  = op[i];                // msb first, eight clocks to the byte
            #(HALF_NS);
            sck = 1'b1;                 // data stands across the rising edge
            #(HALF_NS);
        end
        // released data line has no pull, so show the inverse rather than a stale bit
        // other opcodes get zeros, as the reserved high address bits want
        si = (op == 8'h57) ? ~si : 1'b0;
        for (int i = 0; i < 8*nrd; i++)
        begin
            sck = 1'b0;
            #(HALF_NS);
            sck = 1'b1;
            #(HALF_NS);
            // sampled late in the high phase, well after the output update
            rd     = {rd[14:0], soOut};
            oeSeen = oeSeen | soOe;
        end
        sck = mode;
        #(HALF_NS);
        csN = 1'b1;
        #(4*HALF_NS);
    endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the flash status, reset and busy control block
`timescale 1ns/1ns
module tb;
    import flash_ctrl_pkg::*;
    // shortened operation times keep the run brief
    localparam int         XFR_N = 300;
    localparam int         EP_N  = 900;
    localparam int         P_N   = 600;
    // density code value is arbitrary
    localparam logic [2:0] DENS  = 3'h5;

    logic        clk;
    logic        srst;
    logic        resetN;
    logic        csN;
    logic        sck;
    logic        si;
    logic        soOut;
    logic        soOe;
    logic        rdyBusyOut;
    logic        rdyBusyOe;
    logic        opStart;
    op_kind_t    opKind;
    logic        opBuffer;
    logic        cmpMismatch;
    logic        opAccepted;
    logic        opDone;
    logic        spiMode;
    logic [1:0]  bufferLocked;
    logic        statusCmd;
    logic [15:0] rd;
    logic        oe;
    int          bad_count;
    int          n_checks;

    serial_flash_status_reset_ctrl #(
        .XFR_CYC      (XFR_N),
        .EP_CYC       (EP_N),
        .P_CYC        (P_N),
        .DENSITY_CODE (DENS)
    ) dut (
        .clk          (clk),
        .srst         (srst),
        .resetN       (resetN),
        .csN          (csN),
        .sck          (sck),
        .si           (si),
        .soOut        (soOut),
        .soOe         (soOe),
        .rdyBusyOut   (rdyBusyOut),
        .rdyBusyOe    (rdyBusyOe),
        .opStart      (opStart),
        .opKind       (opKind),
        .opBuffer     (opBuffer),
        .cmpMismatch  (cmpMismatch),
        .opAccepted   (opAccepted),
        .opDone       (opDone),
        .spiMode      (spiMode),
        .bufferLocked (bufferLocked),
        .statusCmd    (statusCmd)
    );

    spi_host_model host (
        .csN   (csN),
        .sck   (sck),
        .si    (si),
        .soOut (soOut),
        .soOe  (soOe)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] st(input logic rdy, input logic cmp);
        return {rdy, cmp, DENS, 3'h0};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, checks %0d, mismatches %0d", name, n_checks, bad_count);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // request one operation; it is held into the first busy cycle to be refused there
    task automatic start_op(input op_kind_t k, input logic b, input logic mis);
        @(posedge clk) #1;
        opStart     = 1'b1;
        opKind      = k;
        opBuffer    = b;
        cmpMismatch = mis;
        #1;
        check(opAccepted, 1'b1, "op taken");
        @(posedge clk) #1;
        check(opAccepted, 1'b0, "op refused while busy");
        opStart = 1'b0;
    endtask

    task automatic run_op(input op_kind_t k, input logic b, input logic mis);
        int n;
        int doneAt;
        int expN;
        expN   = (k == OP_ERASE_PROG) ? EP_N : (k == OP_PROG) ? P_N : XFR_N;
        n      = 0;
        doneAt = 0;
        start_op(k, b, mis);
        while (rdyBusyOe === 1'b1 && n < EP_N + 10)
        begin
            n++;
            if (opDone === 1'b1)
                doneAt = n;
            check(bufferLocked, b ? 2'h2 : 2'h1, "buffer locked");
            @(posedge clk) #2;
        end
        check(16'(n), 16'(expN), "busy length");
        check(16'(doneAt), 16'(expN), "done in last cycle");
        check(bufferLocked, 2'h0, "buffers free");
    endtask

    task automatic pulse_reset_pin;
        @(posedge clk) #1;
        resetN = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        resetN = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask

    initial
    begin
        bad_count   = 0;
        n_checks    = 0;
        srst        = 1'b1;
        resetN      = 1'b1;
        opStart     = 1'b0;
        opKind      = OP_XFR;
        opBuffer    = 1'b0;
        cmpMismatch = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        check(spiMode, MODE_3, "mode after power-on");
        check(soOe, 1'b0, "output floats");
        check(rdyBusyOe, 1'b0, "idle after power-on");
        check(rdyBusyOut, 1'b0, "open drain level");
        end_test("power-on");

        host.xfer(MODE_0, OP_STATUS_READ, 2, rd, oe);
        check(rd, {st(1'b1, 1'b0), st(1'b1, 1'b0)}, "status repeats");
        check(spiMode, MODE_0, "mode 0 picked");
        check(oe, 1'b1, "status driven");
        check(soOe, 1'b0, "output floats after frame");
        host.xfer(MODE_3, OP_STATUS_READ, 1, rd, oe);
        check(rd[7:0], st(1'b1, 1'b0), "status in mode 3");
        check(spiMode, MODE_3, "mode 3 picked");
        host.xfer(MODE_3, 8'h53, 1, rd, oe);
        check(oe, 1'b0, "other opcode not answered");
        end_test("serial link");

        for (int k = 0; k < 4; k++)
            run_op(op_kind_t'(k), k[0], 1'b0);
        run_op(OP_CMP, 1'b0, 1'b1);
        host.xfer(MODE_3, OP_STATUS_READ, 1, rd, oe);
        check(rd[7:0], st(1'b1, 1'b1), "compare differed");
        run_op(OP_CMP, 1'b1, 1'b0);
        host.xfer(MODE_0, OP_STATUS_READ, 1, rd, oe);
        check(rd[7:0], st(1'b1, 1'b0), "compare matched");
        end_test("operations");

        fork
            run_op(OP_ERASE_PROG, 1'b1, 1'b0);
            begin
                repeat (20) @(posedge clk);
                #1;
                host.xfer(MODE_0, OP_STATUS_READ, 1, rd, oe);
                check(rd[7:0], st(1'b0, 1'b0), "busy in status");
            end
            begin
                // middle of the status byte of the frame above
                repeat (150) @(posedge clk);
                #2;
                check(statusCmd, 1'b1, "status phase flagged");
            end
        join
        check(statusCmd, 1'b0, "status phase over");
        end_test("busy status");

        run_op(OP_CMP, 1'b0, 1'b1);
        start_op(OP_PROG, 1'b1, 1'b0);
        repeat (50) @(posedge clk);
        #1;
        resetN = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        opStart = 1'b1;
        #1;
        check(rdyBusyOe, 1'b0, "op aborted");
        check(bufferLocked, 2'h0, "buffers freed");
        check(spiMode, MODE_3, "mode back to 3");
        check(opAccepted, 1'b0, "held in reset");
        repeat (5) @(posedge clk);
        #1;
        check(rdyBusyOe, 1'b0, "still held in reset");
        opStart = 1'b0;
        resetN  = 1'b1;
        repeat (5) @(posedge clk);
        run_op(OP_XFR, 1'b0, 1'b0);
        host.xfer(MODE_3, OP_STATUS_READ, 1, rd, oe);
        check(rd[7:0], st(1'b1, 1'b0), "compare cleared");
        host.hold_cs(1'b0);
        pulse_reset_pin();
        host.xfer(MODE_3, OP_STATUS_READ, 1, rd, oe);
        check(oe, 1'b0, "no frame without cs fall");
        host.xfer(MODE_3, OP_STATUS_READ, 1, rd, oe);
        check(rd[7:0], st(1'b1, 1'b0), "frame after cs fall");
        end_test("reset pin");
        stop_test();
    end

    // whole run is near 120 us; a hang is cut off well beyond that
    initial
    begin
        #1000000;
        bad_count++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end
endmodule
